/* File: bench/cpu_bus_model.sv */
// CPU-side master of the timer register bus
`timescale 1ns/100ps
module cpu_bus_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] bus_rdata,
  output logic      [7:0]  bus_addr,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [1:0]  bus_be,
  output logic      [15:0] bus_wdata
);
  initial begin
    bus_addr  = 8'hFF;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_be    = 2'h0;
    bus_wdata = 16'h0000;
  end
  // Word or byte lanes, held over exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge sys_clk);
    bus_addr  = a;
    bus_be    = be;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(negedge sys_clk);
    bus_wr    = 1'b0;
    bus_wdata = ~d; // Idle data must not mimic the last write
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    d      = bus_rdata;
  endtask
endmodule

/* File: bench/timer_core_monitor.sv */
// Port-level assertions for the five-channel timer core
`timescale 1ns/100ps
module timer_core_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        standby,
  input wire logic [7:0]  bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [1:0]  bus_be,
  input wire logic [15:0] bus_wdata,
  input wire logic [3:0]  ext_clk,
  input wire logic [9:0]  cap_in,
  input wire logic [15:0] bus_rdata,
  input wire logic [9:0]  pin_out,
  input wire logic [9:0]  pin_oe,
  input wire logic [1:0]  comp_out,
  input wire logic [1:0]  comp_oe
);
  logic [5:0] omer_sh;
  logic [2:0] otlc_sh;
  logic [2:0] stat_seen;
  logic       stat_pend;
  logic       trig_ever;
  logic [5:0] oe6;
  assign oe6 = {comp_oe, pin_oe[7], pin_oe[9], pin_oe[8], pin_oe[6]};
  // Software view only; the trigger may clear enables behind its back, never set them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst || standby) begin
      omer_sh   <= 6'h3F;
      otlc_sh   <= 3'h7;
      trig_ever <= 1'b0;
    end else begin
      trig_ever <= trig_ever | ~otlc_sh[2];
      if (bus_wr && bus_be[0] && bus_addr == 8'h04) omer_sh <= bus_wdata[5:0];
      if (bus_wr && bus_be[0] && bus_addr == 8'h06) otlc_sh <= {bus_wdata[4], bus_wdata[1:0]};
    end
  end
  // Last seen channel 0 flags; any write there forgets them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst || standby) begin
      stat_pend <= 1'b0;
      stat_seen <= 3'h0;
    end else begin
      stat_pend <= bus_rd && bus_addr == 8'h14;
      if (bus_wr && bus_addr == 8'h14) stat_seen <= 3'h0;
      else if (stat_pend) stat_seen <= bus_rdata[2:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_otlc_read_ones: assert property (
    bus_rd && !standby && bus_addr == 8'h06 |=> (bus_rdata & 16'hFFEC) == 16'h00EC)
    else $error("output control spare bits not one");
  a_otlc_value: assert property (
    bus_rd && !standby && bus_addr == 8'h06 |=> {bus_rdata[4], bus_rdata[1:0]} == otlc_sh)
    else $error("output control value wrong");
  a_trig_blocked: assert property (
    !trig_ever && otlc_sh[2] && bus_rd && !standby && bus_addr == 8'h04
    |=> bus_rdata[5:0] == omer_sh)
    else $error("master enables changed with trigger off");
  a_rdata_holds: assert property (
    !bus_rd && !standby |=> standby || $stable(bus_rdata))
    else $error("read data moved without a read");
  a_no_buffer_low: assert property (
    bus_rd && !standby && bus_addr[7:4] inside {4'h1, 4'h2, 4'h3} && bus_addr[3:2] == 2'h3
    |=> bus_rdata == 16'h0000)
    else $error("buffer present on low channel");
  a_standby_quiet: assert property (
    standby |=> pin_oe == 10'h000 && comp_oe == 2'h0)
    else $error("pin driven in standby");
  a_master_off_pin: assert property (
    $stable(omer_sh) [*4] |-> (oe6 & ~omer_sh) == 6'h00)
    else $error("pin driven with master enable off");
  a_flags_sticky: assert property (
    bus_rd && !standby && bus_addr == 8'h14 |=> (bus_rdata[2:0] & stat_seen) == stat_seen)
    else $error("status flag lost without clear");
endmodule
bind timer_count_compare_core timer_core_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
  .standby(standby), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
  .bus_wdata(bus_wdata), .ext_clk(ext_clk), .cap_in(cap_in), .bus_rdata(bus_rdata),
  .pin_out(pin_out), .pin_oe(pin_oe), .comp_out(comp_out), .comp_oe(comp_oe));

/* File: bench/timer_count_compare_core_test.sv */
// Self-checking bench for the five-channel timer core
`timescale 1ns/100ps
module timer_count_compare_core_test;
  logic        sys_clk, rst, standby, bus_wr, bus_rd;
  logic [7:0]  bus_addr;
  logic [1:0]  bus_be, comp_out, comp_oe;
  logic [15:0] bus_wdata, bus_rdata, rdv;
  logic [3:0]  ext_clk;
  logic [9:0]  cap_in, pin_out, pin_oe;
  logic [5:0]  lv0;
  int          num_errors;
  int          samples_checked;
  timer_count_compare_core u_dut (.sys_clk(sys_clk), .rst(rst), .standby(standby),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .ext_clk(ext_clk), .cap_in(cap_in), .bus_rdata(bus_rdata),
    .pin_out(pin_out), .pin_oe(pin_oe), .comp_out(comp_out), .comp_oe(comp_oe));
  cpu_bus_model u_cpu (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be), .bus_wdata(bus_wdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] m,
                    input logic [15:0] exp);
    u_cpu.rd(a, rdv);
    chk(nm, exp, rdv & m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(negedge sys_clk) ext_clk[0] = 1'b1;
      @(negedge sys_clk) ext_clk[0] = 1'b0;
    end
    idle(4);
  endtask
  task automatic cap_rise(input int i);
    @(negedge sys_clk) cap_in[i] = 1'b0;
    idle(2);
    cap_in[i] = 1'b1;
    idle(4);
  endtask
  function automatic logic [15:0] pins();
    return {10'h000, pin_out[9:6], comp_out};
  endfunction
  task automatic t_regs;
    rc("omer reset", 8'h04, 16'hFFFF, 16'h00FF);
    rc("otlc reset", 8'h06, 16'hFFFF, 16'h00FF);
    rc("gra0 reset", 8'h18, 16'hFFFF, 16'hFFFF);
    u_cpu.wr(8'h06, 2'h3, 16'h0000);
    rc("otlc spare", 8'h06, 16'hFFFF, 16'h00EC);
    u_cpu.wr(8'h10, 2'h1, 16'h0004);
    u_cpu.wr(8'h16, 2'h3, 16'h1234);
    u_cpu.wr(8'h16, 2'h2, 16'hAB00);
    rc("cnt0 byte", 8'h16, 16'hFFFF, 16'hAB34);
    u_cpu.wr(8'h1A, 2'h1, 16'h0077);
    rc("grb0 byte", 8'h1A, 16'hFFFF, 16'hFF77);
    rc("bra0", 8'h1C, 16'hFFFF, 16'h0000);
    u_cpu.wr(8'h06, 2'h1, 16'h00FF);
  endtask
  task automatic t_wrap;
    u_cpu.wr(8'h16, 2'h3, 16'hFFFE);
    ext_pulses(2);
    rc("wrap flag", 8'h14, 16'h0004, 16'h0004);
    ext_pulses(1);
    rc("wrap kept", 8'h14, 16'h0004, 16'h0004);
    u_cpu.wr(8'h14, 2'h1, 16'h0000);
    rc("flags cleared", 8'h14, 16'h0007, 16'h0000);
    // Phase counting on channel 2: a lone rise on input 0 steps down from zero
    u_cpu.wr(8'h00, 2'h1, 16'h0040);
    u_cpu.wr(8'h36, 2'h3, 16'h0000);
    @(negedge sys_clk) ext_clk[0] = 1'b1;
    idle(3);
    rc("cnt2 down", 8'h36, 16'hFFFF, 16'hFFFF);
    rc("wrap down", 8'h34, 16'h0004, 16'h0004);
    ext_clk[0] = 1'b0;
    u_cpu.wr(8'h00, 2'h1, 16'h0000);
  endtask
  task automatic t_match_clear;
    u_cpu.wr(8'h18, 2'h3, 16'h0005);
    u_cpu.wr(8'h16, 2'h3, 16'h0000);
    u_cpu.wr(8'h10, 2'h1, 16'h0024);
    u_cpu.wr(8'h12, 2'h1, 16'h0002);
    ext_pulses(5);
    rc("cnt0 cleared", 8'h16, 16'hFFFF, 16'h0000);
    rc("match flag a", 8'h14, 16'h0007, 16'h0001);
    chk("pin a0 high", 16'h0003, {14'h0000, pin_oe[0], pin_out[0]});
  endtask
  task automatic t_capture;
    u_cpu.wr(8'h10, 2'h1, 16'h0004);
    u_cpu.wr(8'h14, 2'h1, 16'h0000);
    u_cpu.wr(8'h12, 2'h1, 16'h0040);
    u_cpu.wr(8'h16, 2'h3, 16'h0033);
    cap_rise(1);
    rc("grb0 capture", 8'h1A, 16'hFFFF, 16'h0033);
    rc("capture flag", 8'h14, 16'h0007, 16'h0002);
  endtask
  task automatic t_trigger;
    u_cpu.wr(8'h02, 2'h1, 16'h0020);
    u_cpu.wr(8'h22, 2'h1, 16'h0004);
    cap_rise(2);
    rc("trig off", 8'h04, 16'hFFFF, 16'h00FF);
    u_cpu.wr(8'h06, 2'h1, 16'h00EF);
    cap_rise(2);
    rc("trig on", 8'h04, 16'hFFFF, 16'h00C0);
    u_cpu.wr(8'h02, 2'h1, 16'h0000);
    u_cpu.wr(8'h04, 2'h1, 16'h003F);
    cap_rise(2);
    rc("trig normal", 8'h04, 16'hFFFF, 16'h00FF);
  endtask
  // Counters of channels 3 and 4 are parked on a quiet clock so pin levels stay still
  task automatic t_levels;
    u_cpu.wr(8'h40, 2'h1, 16'h0007);
    u_cpu.wr(8'h50, 2'h1, 16'h0007);
    u_cpu.wr(8'h06, 2'h1, 16'h00FF);
    u_cpu.wr(8'h02, 2'h1, 16'h0020);
    idle(6);
    lv0 = pins();
    u_cpu.wr(8'h06, 2'h1, 16'h00FD);
    idle(6);
    chk("level a", {10'h000, lv0 ^ 6'h34}, pins());
    u_cpu.wr(8'h06, 2'h1, 16'h00FE);
    idle(6);
    chk("level b", {10'h000, lv0 ^ 6'h0B}, pins());
    u_cpu.wr(8'h04, 2'h1, 16'h0035);
    idle(6);
    chk("master enable", 16'h0027, {10'h000, pin_oe[9:6], comp_oe});
    u_cpu.wr(8'h02, 2'h1, 16'h0000);
    idle(6);
    lv0 = pins();
    u_cpu.wr(8'h06, 2'h1, 16'h00FC);
    idle(6);
    chk("level normal", {10'h000, lv0}, pins());
  endtask
  task automatic t_standby;
    u_cpu.wr(8'h10, 2'h1, 16'h0004);
    u_cpu.wr(8'h16, 2'h3, 16'h1234);
    @(negedge sys_clk) standby = 1'b1;
    idle(2);
    standby = 1'b0;
    u_cpu.rd(8'h16, rdv);
    chk("cnt0 restart", 16'h0001, {15'h0000, rdv < 16'h0010});
    rc("otlc standby", 8'h06, 16'hFFFF, 16'h00FF);
    rc("gra0 standby", 8'h18, 16'hFFFF, 16'hFFFF);
  endtask
  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst             = 1'b1;
    standby         = 1'b0;
    ext_clk         = 4'h0;
    cap_in          = 10'h000;
    num_errors      = 0;
    samples_checked = 0;
    idle(6);
    rst = 1'b0;
    t_regs();
    t_wrap();
    t_match_clear();
    t_capture();
    t_trigger();
    t_levels();
    t_standby();
    test_done();
  end
  // The sequence needs well under a thousand cycles; twenty thousand means a hang
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule

/* File: include/timer_pkg.sv */
// Shared constants and types for the five-channel timer core
package timer_pkg;
  localparam int NUM_CH = 5;

  // Global register indexes, byte address = 2 * index, channel nibble 0
  localparam logic [2:0] GIDX_MODE = 3'h0;
  localparam logic [2:0] GIDX_FUNC = 3'h1;
  localparam logic [2:0] GIDX_OMER = 3'h2;
  localparam logic [2:0] GIDX_OTLC = 3'h3;

  // Per-channel register indexes, channel n at address nibble n + 1
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_IO   = 3'h1;
  localparam logic [2:0] IDX_STAT = 3'h2;
  localparam logic [2:0] IDX_CNT  = 3'h3;
  localparam logic [2:0] IDX_GRA  = 3'h4;
  localparam logic [2:0] IDX_GRB  = 3'h5;
  localparam logic [2:0] IDX_BRA  = 3'h6;
  localparam logic [2:0] IDX_BRB  = 3'h7;

  // Field positions
  localparam int MODE_PHASE_BIT = 6;
  localparam int FUNC_MODE_LSB  = 4;
  localparam int OTLC_TRIG_BIT  = 4;
  localparam int OTLC_LSA_BIT   = 1;
  localparam int OTLC_LSB_BIT   = 0;
  localparam int OM_CH3A = 0;
  localparam int OM_CH4A = 1;
  localparam int OM_CH4B = 2;
  localparam int OM_CH3B = 3;
  localparam int OM_CX4A = 4;
  localparam int OM_CX4B = 5;
  localparam int IO_CAP_BIT = 2;

  // Reset values and read-as-one masks
  localparam logic [7:0]  OTLC_RESET   = 8'hFF;
  localparam logic [7:0]  OTLC_RO_ONES = 8'hEC;
  localparam logic [5:0]  OMER_RESET   = 6'h3F;
  localparam logic [7:0]  OMER_RO_ONES = 8'hC0;
  localparam logic [7:0]  CTRL_RO_ONES = 8'h80;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] GR_RESET     = 16'hFFFF;

  localparam logic [1:0] CLR_A     = 2'h1;
  localparam logic [1:0] CLR_B     = 2'h2;
  localparam logic [1:0] OC_NONE   = 2'h0;
  localparam logic [1:0] OC_LOW    = 2'h1;
  localparam logic [1:0] OC_HIGH   = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_RSPWM  = 2'b10,
    PM_CPWM   = 2'b11
  } pair_mode_t;

  typedef struct packed {
    logic [1:0]      clr;
    logic [2:0]      psel;
    logic [1:0][2:0] io;
  } chan_cfg_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  idx;
    logic [1:0]  be;
    logic [15:0] data;
  } chan_wr_t;
endpackage

/* File: logic/timer_channel.sv */
// One timer channel: counter, two compare/capture registers, buffers
`timescale 1ns/100ps
module timer_channel #(
  parameter bit HAS_BUF = 1'b0
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  standby,
  input  wire timer_pkg::chan_cfg_t  cfg,
  input  wire timer_pkg::chan_wr_t   wr,
  input  wire logic                  tick,
  input  wire logic                  phase_mode,
  input  wire logic                  phase_step,
  input  wire logic                  phase_up,
  input  wire logic                  updown,
  input  wire logic [15:0]           top,
  input  wire logic                  pwm,
  input  wire logic [1:0]            buf_en,
  input  wire logic [1:0]            cap_in,
  output logic [15:0]                cnt,
  output logic [1:0][15:0]           gr,
  output logic [1:0][15:0]           bufv,
  output logic [1:0]                 ev,
  output logic [1:0]                 cap_ev,
  output logic                       wrap,
  output logic [1:0]                 outv
);
  import timer_pkg::*;

  logic [1:0]  cap_q;
  logic        dir;
  logic        moved;
  logic        step;
  logic        down;
  logic        cnt_wr;
  logic        clear;
  logic [15:0] next_cnt;
  logic [1:0]  match;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  always_comb begin
    if (phase_mode) begin
      step = phase_step;
      down = !phase_up;
    end else begin
      step = tick;
      down = updown && dir;
    end
    next_cnt = down ? cnt - 16'h0001 : cnt + 16'h0001;
  end

  assign cnt_wr = wr.en && (wr.idx == IDX_CNT) && (|wr.be);
  assign clear  = (cfg.clr == CLR_A && ev[0]) || (cfg.clr == CLR_B && ev[1]);
  assign wrap   = step && !cnt_wr && !clear
                  && (cnt == (down ? 16'h0000 : 16'hFFFF));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cap_q <= 2'h0;
      moved <= 1'b0;
      dir   <= 1'b0;
    end else if (standby) begin
      cap_q <= 2'h0;
      moved <= 1'b0;
      dir   <= 1'b0;
    end else begin
      cap_q <= cap_in;
      moved <= step || cnt_wr;
      if (!updown || phase_mode) begin
        dir <= 1'b0;
      end else if (step && !dir && next_cnt == top) begin
        dir <= 1'b1;
      end else if (step && dir && next_cnt == 16'h0000) begin
        dir <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= CNT_RESET;
    end else if (standby) begin
      cnt <= CNT_RESET;
    end else if (cnt_wr) begin
      cnt <= merge(cnt, wr.data, wr.be);
    end else if (clear) begin
      cnt <= CNT_RESET;
    end else if (step) begin
      cnt <= next_cnt;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_gr
    logic is_cap;
    logic rise;
    logic fall;
    logic buf_on;

    // PWM modes force compare use whatever the capture bit says
    assign is_cap    = cfg.io[i][IO_CAP_BIT] && !pwm;
    assign rise      = cap_in[i] && !cap_q[i];
    assign fall      = !cap_in[i] && cap_q[i];
    assign cap_ev[i] = is_cap && (cfg.io[i][1] ? (rise || fall)
                       : (cfg.io[i][1:0] == EDGE_FALL) ? fall : rise);
    // Compare only after the counter moved, so a static equal value fires once
    assign match[i]  = moved && !is_cap && (cnt == gr[i]);
    assign ev[i]     = match[i] || cap_ev[i];
    assign buf_on    = HAS_BUF && buf_en[i];

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        gr[i] <= GR_RESET;
      end else if (standby) begin
        gr[i] <= GR_RESET;
      end else if (wr.en && wr.idx == 3'(IDX_GRA + i)) begin
        gr[i] <= merge(gr[i], wr.data, wr.be);
      end else if (cap_ev[i]) begin
        gr[i] <= cnt;
      end else if (match[i] && buf_on) begin
        gr[i] <= bufv[i];
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        bufv[i] <= GR_RESET;
      end else if (standby) begin
        bufv[i] <= GR_RESET;
      end else if (HAS_BUF && wr.en && wr.idx == 3'(IDX_BRA + i)) begin
        bufv[i] <= merge(bufv[i], wr.data, wr.be);
      end else if (cap_ev[i] && buf_on) begin
        bufv[i] <= gr[i];
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        outv[i] <= 1'b0;
      end else if (standby) begin
        outv[i] <= 1'b0;
      end else if (pwm) begin
        if (match[i]) begin
          outv[i] <= 1'b1;
        end else if (match[1 - i]) begin
          outv[i] <= 1'b0;
        end
      end else if (match[i]) begin
        unique case (cfg.io[i][1:0])
          OC_NONE: outv[i] <= outv[i];
          OC_LOW:  outv[i] <= 1'b0;
          OC_HIGH: outv[i] <= 1'b1;
          default: outv[i] <= !outv[i];
        endcase
      end
    end
  end
endmodule

/* File: logic/timer_count_compare_core.sv */
// Five-channel 16-bit timer core with compare, capture and output control
`timescale 1ns/100ps
// Contract
// - Unused output-control bits read as one
// - Output control resets to FF, also standby
// - Trigger and levels act only paired modes
// - Trigger enabled: ch1 capture A clears enables
// - Trigger disabled: ch1 capture A harmless
// - Group A level bit zero inverts outputs
// - Group B level bit zero inverts outputs
// - Each channel has 16-bit prescaled counter
// - Count direction depends on channel and mode
// - Counter clears on own A/B event
// - Upward wrap sets channel wrap flag
// - Downward wrap sets channel wrap flag
// - Counters take word and byte access
// - Counters reset to zero, also standby
// - Two compare/capture registers per channel
// - Compare match sets flag, drives output
// - Selected capture edge latches count, sets flag
// - PWM modes ignore I/O control settings
// - General registers take word, byte access
// - General registers reset to FFFF, compare
// - Only channels three, four have buffers
// - Cleared master enable releases the pin
// - Buffer copies into register on match
module timer_count_compare_core (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        standby,
  input  wire logic [7:0]  bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [1:0]  bus_be,
  input  wire logic [15:0] bus_wdata,
  input  wire logic [3:0]  ext_clk,
  input  wire logic [9:0]  cap_in,
  output logic      [15:0] bus_rdata,
  output logic      [9:0]  pin_out,
  output logic      [9:0]  pin_oe,
  output logic      [1:0]  comp_out,
  output logic      [1:0]  comp_oe
);
  import timer_pkg::*;

  logic [3:0]       ch_num;
  logic [2:0]       idx;
  logic             glob_wr;
  logic [15:0]      next_rdata;

  logic [2:0]       pre;
  logic [3:0]       ext_q;
  logic [7:0]       src;
  logic             ph_step;
  logic             ph_up;

  logic [4:0]       pwm_en;
  logic             phase_mode;
  logic [3:0]       buf_en;
  pair_mode_t       pmode;
  logic             rs_mode;
  logic             cp_mode;
  logic             pair_mode;
  logic [5:0]       omer;
  logic             trig_off;
  logic             lvl_a;
  logic             lvl_b;
  logic             trigger;

  chan_cfg_t        cfg    [NUM_CH];
  logic [2:0]       flags  [NUM_CH];
  logic [15:0]      cnt    [NUM_CH];
  logic [1:0][15:0] gr     [NUM_CH];
  logic [1:0][15:0] bufv   [NUM_CH];
  logic [1:0]       ev     [NUM_CH];
  logic [1:0]       cap_ev [NUM_CH];
  logic             wrap   [NUM_CH];
  logic [1:0]       outv   [NUM_CH];

  logic [9:0]       lvl;
  logic [9:0]       drive;
  logic [9:0]       inv;
  logic [9:0]       gate;

  assign ch_num  = bus_addr[7:4];
  assign idx     = bus_addr[3:1];
  assign glob_wr = bus_wr && (ch_num == 4'h0) && bus_be[0];

  // Clock sources: internal divide by 1/2/4/8, then four external inputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre   <= 3'h0;
      ext_q <= 4'h0;
    end else begin
      pre   <= pre + 3'h1;
      ext_q <= ext_clk;
    end
  end

  assign src     = {ext_clk & ~ext_q, &pre[2:0], &pre[1:0], pre[0], 1'b1};
  // Two-phase decode on external inputs 0 and 1; any change is one step
  assign ph_step = (ext_clk[1:0] != ext_q[1:0]);
  assign ph_up   = ext_q[0] ^ ext_clk[1];

  always_comb begin
    rs_mode = 1'b0;
    cp_mode = 1'b0;
    unique case (pmode)
      PM_RSPWM:  rs_mode = 1'b1;
      PM_CPWM:   cp_mode = 1'b1;
      default:   rs_mode = 1'b0;
    endcase
  end

  assign pair_mode = rs_mode || cp_mode;
  // External shutdown only counts while a paired mode runs
  assign trigger   = !trig_off && pair_mode && cap_ev[1][0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_en     <= 5'h00;
      phase_mode <= 1'b0;
    end else if (standby) begin
      pwm_en     <= 5'h00;
      phase_mode <= 1'b0;
    end else if (glob_wr && idx == GIDX_MODE) begin
      pwm_en     <= bus_wdata[4:0];
      phase_mode <= bus_wdata[MODE_PHASE_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buf_en <= 4'h0;
      pmode  <= PM_NORMAL;
    end else if (standby) begin
      buf_en <= 4'h0;
      pmode  <= PM_NORMAL;
    end else if (glob_wr && idx == GIDX_FUNC) begin
      buf_en <= bus_wdata[3:0];
      pmode  <= pair_mode_t'(bus_wdata[FUNC_MODE_LSB +: 2]);
    end
  end

  // The shutdown beats a same-cycle software write, so that write cannot undo it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      omer <= OMER_RESET;
    end else if (standby) begin
      omer <= OMER_RESET;
    end else if (trigger) begin
      omer <= 6'h00;
    end else if (glob_wr && idx == GIDX_OMER) begin
      omer <= bus_wdata[5:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_off <= OTLC_RESET[OTLC_TRIG_BIT];
      lvl_a    <= OTLC_RESET[OTLC_LSA_BIT];
      lvl_b    <= OTLC_RESET[OTLC_LSB_BIT];
    end else if (standby) begin
      trig_off <= OTLC_RESET[OTLC_TRIG_BIT];
      lvl_a    <= OTLC_RESET[OTLC_LSA_BIT];
      lvl_b    <= OTLC_RESET[OTLC_LSB_BIT];
    end else if (glob_wr && idx == GIDX_OTLC) begin
      trig_off <= bus_wdata[OTLC_TRIG_BIT];
      lvl_a    <= bus_wdata[OTLC_LSA_BIT];
      lvl_b    <= bus_wdata[OTLC_LSB_BIT];
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic       sel;
    logic       stat_wr;
    logic       pwm_c;
    logic [1:0] bsel;
    chan_wr_t   wr;

    assign sel     = bus_wr && (ch_num == 4'(c + 1));
    assign stat_wr = sel && (idx == IDX_STAT) && bus_be[0];
    assign wr      = '{en: sel, idx: idx, be: bus_be, data: bus_wdata};
    assign pwm_c   = pwm_en[c] || ((c >= 3) && pair_mode);

    if (c >= 3) begin : g_buf
      assign bsel = buf_en[2 * c - 6 +: 2];
    end else begin : g_nobuf
      assign bsel = 2'h0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        cfg[c] <= '0;
      end else if (standby) begin
        cfg[c] <= '0;
      end else if (sel && bus_be[0] && idx == IDX_CTRL) begin
        cfg[c].clr  <= bus_wdata[6:5];
        cfg[c].psel <= bus_wdata[2:0];
      end else if (sel && bus_be[0] && idx == IDX_IO) begin
        cfg[c].io[0] <= bus_wdata[2:0];
        cfg[c].io[1] <= bus_wdata[6:4];
      end
    end

    // A new event in the clearing cycle keeps its flag set
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        flags[c] <= 3'h0;
      end else if (standby) begin
        flags[c] <= 3'h0;
      end else begin
        flags[c] <= {wrap[c], ev[c]}
                    | (flags[c] & ~(stat_wr ? ~bus_wdata[2:0] : 3'h0));
      end
    end

    timer_channel #(
      .HAS_BUF (c >= 3)
    ) u_ch (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .standby    (standby),
      .cfg        (cfg[c]),
      .wr         (wr),
      .tick       (src[cfg[c].psel]),
      .phase_mode ((c == 2) && phase_mode),
      .phase_step (ph_step),
      .phase_up   (ph_up),
      .updown     ((c >= 3) && cp_mode),
      .top        (gr[3][0]),
      .pwm        (pwm_c),
      .buf_en     (bsel),
      .cap_in     (cap_in[2 * c +: 2]),
      .cnt        (cnt[c]),
      .gr         (gr[c]),
      .bufv       (bufv[c]),
      .ev         (ev[c]),
      .cap_ev     (cap_ev[c]),
      .wrap       (wrap[c]),
      .outv       (outv[c])
    );

    for (genvar i = 0; i < 2; i++) begin : g_pin
      assign lvl[2 * c + i]   = outv[c][i];
      // In PWM modes side B only drives when channels 3 and 4 are paired
      assign drive[2 * c + i] = pwm_c ? ((i == 0) || ((c >= 3) && pair_mode))
                                : (!cfg[c].io[i][IO_CAP_BIT]
                                   && cfg[c].io[i][1:0] != OC_NONE);
    end
  end

  assign inv  = pair_mode ? {!lvl_a, !lvl_a, !lvl_b, !lvl_a, 6'h00} : 10'h000;
  assign gate = {omer[OM_CH4B], omer[OM_CH4A], omer[OM_CH3B], omer[OM_CH3A], 6'h3F};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_out  <= 10'h000;
      pin_oe   <= 10'h000;
      comp_out <= 2'h0;
      comp_oe  <= 2'h0;
    end else if (standby) begin
      pin_out  <= 10'h000;
      pin_oe   <= 10'h000;
      comp_out <= 2'h0;
      comp_oe  <= 2'h0;
    end else begin
      pin_out  <= lvl ^ inv;
      pin_oe   <= drive & gate;
      comp_out <= {!lvl[9], !lvl[8]} ^ {2{pair_mode && !lvl_b}};
      comp_oe  <= {omer[OM_CX4B], omer[OM_CX4A]} & {2{pair_mode}};
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (ch_num == 4'h0) begin
      unique case (idx)
        GIDX_MODE: next_rdata = {9'h000, phase_mode, 1'b0, pwm_en};
        GIDX_FUNC: next_rdata = {10'h000, pmode, buf_en};
        GIDX_OMER: next_rdata = {8'h00, OMER_RO_ONES | {2'h0, omer}};
        GIDX_OTLC: next_rdata = {8'h00, OTLC_RO_ONES | {3'h0, trig_off, 2'h0, lvl_a, lvl_b}};
        default:   next_rdata = 16'h0000;
      endcase
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (ch_num == 4'(c + 1)) begin
        unique case (idx)
          IDX_CTRL: next_rdata = {8'h00, CTRL_RO_ONES | {1'b0, cfg[c].clr, 2'h0, cfg[c].psel}};
          IDX_IO:   next_rdata = {9'h000, cfg[c].io[1], 1'b0, cfg[c].io[0]};
          IDX_STAT: next_rdata = {13'h0000, flags[c]};
          IDX_CNT:  next_rdata = cnt[c];
          IDX_GRA:  next_rdata = gr[c][0];
          IDX_GRB:  next_rdata = gr[c][1];
          IDX_BRA:  next_rdata = (c >= 3) ? bufv[c][0] : 16'h0000;
          IDX_BRB:  next_rdata = (c >= 3) ? bufv[c][1] : 16'h0000;
        endcase
      end
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end
  end
endmodule
